// [qupc_pin_ctrl.sv]
// Pin control core for a quad asynchronous serial controller.
`timescale 1ns/1ps
module qupc_pin_ctrl
    import qupc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic bus_style_in,
    input wire logic reset_pin_in,
    input wire logic prescaler_strap,
    input wire logic osc_in,
    output logic osc_out,
    input wire logic third_channel_clock_in,
    input wire logic [NCH-1:0] tx_data_in,
    input wire logic [NCH-1:0] tx_busy_in,
    output logic [NCH-1:0] serial_tx_out,
    input wire logic [NCH-1:0] serial_rx_in,
    output logic [NCH-1:0] rx_data_out,
    output logic [NCH-1:0] rx_sample_tick,
    output logic [NCH-1:0] baud16x_clock_out,
    output logic [NCH-1:0] terminal_ready_out_n,
    output logic [NCH-1:0] spare_out1_or_dir_n,
    output logic [NCH-1:0] spare_out2_n,
    input wire logic [NCH-1:0] set_ready_in_n,
    input wire logic [NCH-1:0] carrier_sense_in_n,
    input wire logic [NCH-1:0] ring_sense_in_n,
    output logic strobe_bus_style,
    output logic device_reset
);

    logic [SYNC_W-1:0] pins;       // All pin inputs gathered.
    logic [SYNC_W-1:0] sync1_r;    // First synchroniser stage.
    logic [SYNC_W-1:0] sync2_r;    // Second synchroniser stage.
    logic ext_d_r;                 // Delayed third clock level.
    logic want_rst;                // Reset pin asserted for the bus style.
    logic [2:0] rst_cnt_r;         // Reset pulse length counter.
    logic dev_rst_r;               // Internal device reset.
    logic [1:0] cap_cnt_r;         // Strap sampling window counter.
    logic strap_r;                 // Captured prescaler strap.
    logic [NCH-1:0][7:0] mctl_r;   // Modem control register per channel.
    logic [NCH-1:0][7:0] feat_r;   // Feature control register per channel.
    logic [NCH-1:0][15:0] div_r;   // Baud divisor per channel.
    logic [NCH-1:0] ovr_r;         // Software has set the prescaler.
    logic [NCH-1:0] div4;          // Effective prescaler choice.
    logic [7:0] rd_val;            // Read data before the register.
    logic [7:0] rdata_r;           // Registered read data.
    logic [1:0] ch;                // Channel field of the address.
    logic [NCH-1:0] tx_r;          // Registered transmit outputs.
    logic [NCH-1:0] rx_r;          // Registered receive data.
    logic [NCH-1:0] term_r;        // Registered terminal ready outputs.
    logic [NCH-1:0] sp1_r;         // Registered spare one outputs.
    logic [NCH-1:0] sp2_r;         // Registered spare two outputs.
    logic style_r;                 // Registered bus style.

    qupc_bgen_if bg ();

    // The oscillator output is a buffered copy of the oscillator input.
    assign osc_out = osc_in;

    // Every pin input crosses two flip-flops before any logic sees it.
    assign pins = {ring_sense_in_n, carrier_sense_in_n, set_ready_in_n,
                   serial_rx_in, third_channel_clock_in, prescaler_strap,
                   reset_pin_in, bus_style_in};

    // Two-stage synchroniser for all pins.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // Idle levels keep a false start bit or edge out after reset.
            sync1_r <= SYNC_IDLE;
            sync2_r <= SYNC_IDLE;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    // Delayed copy of the third clock for edge detection.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= sync2_r[SY_XCLK];
        end
    end

    // The reset pin polarity follows the bus style.
    assign want_rst = sync2_r[SY_STYLE] ? sync2_r[SY_RSTPIN]
                                        : !sync2_r[SY_RSTPIN];

    // A reset is taken once the pin has stood for the least pulse time.
    // Shorter glitches never disturb the registers.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rst_cnt_r <= 3'h0;
            dev_rst_r <= 1'b0;
        end else if (!want_rst) begin
            rst_cnt_r <= 3'h0;
            dev_rst_r <= 1'b0;
        end else if (rst_cnt_r == RST_LAST) begin
            dev_rst_r <= 1'b1;
        end else begin
            rst_cnt_r <= rst_cnt_r + 3'h1;
        end
    end

    // The strap is followed during reset and for three cycles after each reset release only.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cap_cnt_r <= 2'h0;
            strap_r <= 1'b0;
        end else begin
            if (dev_rst_r) begin
                cap_cnt_r <= 2'h0;
            end else if (cap_cnt_r != STRAP_SETTLE) begin
                cap_cnt_r <= cap_cnt_r + 2'h1;
            end
            // Later strap changes are ignored.
            if (dev_rst_r || (cap_cnt_r != STRAP_SETTLE)) begin
                strap_r <= sync2_r[SY_STRAP];
            end
        end
    end

    assign ch = reg_addr[3:2];

    // Register writes; the device reset returns them to their defaults.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mctl_r <= {NCH{MCTL_RST}};
            feat_r <= {NCH{FEAT_RST}};
            div_r <= {NCH{DIV_RST}};
            ovr_r <= '0;
        end else if (dev_rst_r) begin
            mctl_r <= {NCH{MCTL_RST}};
            feat_r <= {NCH{FEAT_RST}};
            div_r <= {NCH{DIV_RST}};
            ovr_r <= '0;
        end else if (reg_wr && !reg_addr[ADDR_STATUS_BIT]) begin
            case (reg_addr[1:0])
                REG_MCTL: begin
                    // A write takes the prescaler choice from software.
                    mctl_r[ch] <= reg_wdata;
                    ovr_r[ch] <= 1'b1;
                end
                REG_FEAT: begin
                    feat_r[ch] <= reg_wdata;
                end
                REG_DIVLO: begin
                    div_r[ch][7:0] <= reg_wdata;
                end
                REG_DIVHI: begin
                    div_r[ch][15:8] <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // The strap chooses the prescaler until software overrides it.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            div4[i] = ovr_r[i] ? mctl_r[i][MCTL_PRESC_BIT]
                               : !strap_r;
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        rd_val = 8'h00;
        if (reg_addr[ADDR_STATUS_BIT]) begin
            if (reg_addr[3:2] == 2'h0) begin
                rd_val[ST_DSR] = !sync2_r[SY_DSR + int'(reg_addr[1:0])];
                rd_val[ST_CD] = !sync2_r[SY_CD + int'(reg_addr[1:0])];
                rd_val[ST_RI] = !sync2_r[SY_RI + int'(reg_addr[1:0])];
                rd_val[ST_DIV4] = div4[reg_addr[1:0]];
                rd_val[ST_STRAP] = strap_r;
                rd_val[ST_STROBE] = style_r;
            end
        end else begin
            case (reg_addr[1:0])
                REG_MCTL: rd_val = mctl_r[ch];
                REG_FEAT: rd_val = feat_r[ch];
                REG_DIVLO: rd_val = div_r[ch][7:0];
                REG_DIVHI: rd_val = div_r[ch][15:8];
                default: rd_val = 8'h00;
            endcase
        end
    end

    // Read data stand for exactly the cycle after the read strobe.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_val;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // Serial line: idle high and receive ignored during reset.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_r <= '1;
            rx_r <= '1;
        end else if (dev_rst_r) begin
            tx_r <= '1;
            rx_r <= '1;
        end else begin
            tx_r <= tx_data_in;
            rx_r <= sync2_r[SY_RX +: NCH];
        end
    end

    // Handshake and spare outputs, inverted from their control bits; spare one in direction mode is the inverted busy input.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            term_r <= '1;
            sp1_r <= '1;
            sp2_r <= '1;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                term_r[i] <= !mctl_r[i][MCTL_TERM_BIT];
                sp2_r[i] <= !mctl_r[i][MCTL_OP2_BIT];
                if (feat_r[i][FEAT_DIR_BIT]) begin
                    sp1_r[i] <= !tx_busy_in[i];
                end else begin
                    sp1_r[i] <= !mctl_r[i][MCTL_OP1_BIT];
                end
            end
        end
    end

    // Bus style seen by the host side logic.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            style_r <= 1'b0;
        end else begin
            style_r <= sync2_r[SY_STYLE];
        end
    end

    // Connections to the baud generators.
    assign bg.divisor = div_r;
    assign bg.div4 = div4;
    assign bg.hold = dev_rst_r;
    assign bg.ext_level = sync2_r[SY_XCLK];
    assign bg.ext_tick = sync2_r[SY_XCLK] && !ext_d_r;

    qupc_baud_gen u_baud (
        .core_clk(core_clk),
        .rst(rst),
        .bg(bg.gen)
    );

    assign baud16x_clock_out = bg.clk16;
    assign rx_sample_tick = bg.tick;
    assign serial_tx_out = tx_r;
    assign rx_data_out = rx_r;
    assign terminal_ready_out_n = term_r;
    assign spare_out1_or_dir_n = sp1_r;
    assign spare_out2_n = sp2_r;
    assign reg_rdata = rdata_r;
    assign strobe_bus_style = style_r;
    assign device_reset = dev_rst_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Reset request held in each bus style.
    sequence s_hi_req;
        (sync2_r[SY_STYLE] && sync2_r[SY_RSTPIN])[*4];
    endsequence
    sequence s_lo_req;
        (!sync2_r[SY_STYLE] && !sync2_r[SY_RSTPIN])[*4];
    endsequence
    sequence s_ext_edge;
        !sync2_r[SY_XCLK] ##1 sync2_r[SY_XCLK];
    endsequence

    a_rst_high_pol: assert property (s_hi_req |=> dev_rst_r)
        else $error("strobe style reset not taken");
    a_rst_low_pol: assert property (s_lo_req |=> dev_rst_r)
        else $error("select style reset not taken");
    a_rst_release: assert property (!want_rst |=> !dev_rst_r)
        else $error("device reset outlived the pin");
    a_tx_held_high: assert property (dev_rst_r |=> serial_tx_out == '1)
        else $error("transmit not high in reset");
    a_rx_ignored: assert property (dev_rst_r ##1 dev_rst_r |=> rx_data_out == '1)
        else $error("receive not ignored in reset");
    a_strap_frozen: assert property ((!dev_rst_r && cap_cnt_r == STRAP_SETTLE)
        |=> $stable(strap_r))
        else $error("strap changed outside reset");
    a_strap_select: assert property (!ovr_r[0] |-> div4[0] == !strap_r)
        else $error("strap prescaler choice wrong");
    a_presc_override: assert property ((reg_wr && !dev_rst_r
        && reg_addr == {3'h0, REG_MCTL})
        |=> div4[0] == $past(reg_wdata[MCTL_PRESC_BIT]))
        else $error("prescaler override not applied");
    a_dir_control: assert property (feat_r[0][FEAT_DIR_BIT]
        |=> spare_out1_or_dir_n[0] == !$past(tx_busy_in[0]))
        else $error("direction output wrong");
    a_term_drive: assert property (##1 terminal_ready_out_n[0]
        == !$past(mctl_r[0][MCTL_TERM_BIT]))
        else $error("terminal ready not inverted bit");
    a_ext_tick: assert property (s_ext_edge |-> rx_sample_tick[THIRD_CH])
        else $error("third channel tick missing");
    a_rdata_window: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

endmodule : qupc_pin_ctrl

// [qupc_pkg.sv]
// Constants, register layout and helper functions for the quad pin control.
package qupc_pkg;

    // Number of serial channels handled by the block.
    localparam int NCH = 4;
    // Index of the channel that runs from its own clock input.
    localparam int THIRD_CH = 2;

    // Core clock period and the shortest accepted reset pulse.
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_MIN_NS = 40;
    // Least reset time rounded up to whole cycles.
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] RST_LAST = 3'(RST_MIN_CYC - 1);

    // Cycles after reset release during which the strap is still sampled.
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // Last count of the divide-by-4 prescaler.
    localparam logic [1:0] PRESC_LAST = 2'h3;

    // Register address layout: bit 4 picks the status bank.
    localparam int ADDR_W = 5;
    localparam int ADDR_STATUS_BIT = 4;
    localparam logic [1:0] REG_MCTL = 2'h0;
    localparam logic [1:0] REG_FEAT = 2'h1;
    localparam logic [1:0] REG_DIVLO = 2'h2;
    localparam logic [1:0] REG_DIVHI = 2'h3;

    // Bit positions inside the modem control register.
    localparam int MCTL_TERM_BIT = 0;
    localparam int MCTL_OP1_BIT = 2;
    localparam int MCTL_OP2_BIT = 3;
    localparam int MCTL_PRESC_BIT = 7;
    // Bit position of the direction select in the feature control register.
    localparam int FEAT_DIR_BIT = 3;

    // Bit positions inside a channel status register.
    localparam int ST_DSR = 0;
    localparam int ST_CD = 1;
    localparam int ST_RI = 2;
    localparam int ST_DIV4 = 3;
    localparam int ST_STRAP = 4;
    localparam int ST_STROBE = 5;

    // Values after reset.
    localparam logic [7:0] MCTL_RST = 8'h00;
    localparam logic [7:0] FEAT_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;

    // Positions of the pin inputs in the synchroniser vector.
    localparam int SYNC_W = 20;
    localparam int SY_STYLE = 0;
    localparam int SY_RSTPIN = 1;
    localparam int SY_STRAP = 2;
    localparam int SY_XCLK = 3;
    localparam int SY_RX = 4;
    localparam int SY_DSR = 8;
    localparam int SY_CD = 12;
    localparam int SY_RI = 16;
    // Idle pin levels: strobe style, reset off, clock low, lines high.
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 20'hffff1;

    // A divisor of zero behaves as a divisor of one.
    function automatic logic [15:0] qupc_eff_div(input logic [15:0] d);
        qupc_eff_div = (d == 16'h0000) ? 16'h0001 : d;
    endfunction : qupc_eff_div

endpackage : qupc_pkg

// [qupc_bgen_if.sv]
// Signals between the pin control core and the baud generators.
`timescale 1ns/1ps
interface qupc_bgen_if;
    import qupc_pkg::*;
    logic [NCH-1:0][15:0] divisor; // Divisor per channel.
    logic [NCH-1:0] div4;          // High selects divide-by-4 prescaling.
    logic hold;                    // Holds all generators in reset; the third channel tick still follows its clock.
    logic ext_tick;                // Rising edge seen on the third clock.
    logic ext_level;               // Synchronised level of the third clock.
    logic [NCH-1:0] tick;          // One-cycle 16x sample enable.
    logic [NCH-1:0] clk16;         // Registered 16x clock waveform.
    modport ctl (output divisor, div4, hold, ext_tick, ext_level,
                 input tick, clk16);
    modport gen (input divisor, div4, hold, ext_tick, ext_level,
                 output tick, clk16);
endinterface : qupc_bgen_if

// [qupc_baud_gen.sv]
// Four baud rate generators with prescaler and 16x clock output.
`timescale 1ns/1ps
module qupc_baud_gen
    import qupc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    qupc_bgen_if.gen bg
);

    logic [NCH-1:0][1:0] pre_cnt_r;  // Prescaler counters.
    logic [NCH-1:0][15:0] cnt_r;     // Divisor counters.
    logic [NCH-1:0] tick_r;          // Internal generator ticks.
    logic [NCH-1:0] clk16_r;         // Registered 16x waveforms.
    logic [NCH-1:0] pre_en;          // Prescaled enable per channel.

    // The prescaler passes every cycle or one cycle in four.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            pre_en[i] = !bg.div4[i] || (pre_cnt_r[i] == PRESC_LAST);
        end
    end

    // Prescaler counters run freely except while held.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_cnt_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (bg.hold) begin
                    pre_cnt_r[i] <= 2'h0;
                end else begin
                    pre_cnt_r[i] <= pre_cnt_r[i] + 2'h1;
                end
            end
        end
    end

    // Divisor counters emit one tick per divisor period.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            tick_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (bg.hold) begin
                    cnt_r[i] <= 16'h0000;
                    tick_r[i] <= 1'b0;
                end else if (pre_en[i]) begin
                    // Wrap at the last count and mark the period.
                    if (cnt_r[i] >= qupc_eff_div(bg.divisor[i]) - 16'h0001) begin
                        cnt_r[i] <= 16'h0000;
                        tick_r[i] <= 1'b1;
                    end else begin
                        cnt_r[i] <= cnt_r[i] + 16'h0001;
                        tick_r[i] <= 1'b0;
                    end
                end else begin
                    tick_r[i] <= 1'b0;
                end
            end
        end
    end

    // Except on the third channel, which copies its clock level, the waveform is high in the upper half of the divisor period.
    // A divisor of one gives a steady high level; only the tick counts.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk16_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (bg.hold) begin
                    clk16_r[i] <= 1'b0;
                end else if (i == THIRD_CH) begin
                    clk16_r[i] <= bg.ext_level;
                end else begin
                    clk16_r[i] <= cnt_r[i] >= (qupc_eff_div(bg.divisor[i]) >> 1);
                end
            end
        end
    end

    // The third channel takes its ticks from its own clock input.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            bg.tick[i] = (i == THIRD_CH) ? bg.ext_tick : tick_r[i];
        end
    end

    assign bg.clk16 = clk16_r;

endmodule : qupc_baud_gen

// [qupc_line_model.sv]
// Line transceiver and modem model on the serial side of the block.
`timescale 1ns/1ps
module qupc_line_model
    import qupc_pkg::*;
(
    input wire logic core_clk,
    input wire logic clk_on,
    input wire logic line_break,
    input wire logic [NCH-1:0] dsr_on,
    input wire logic [NCH-1:0] serial_tx_out,
    output logic [NCH-1:0] serial_rx_in,
    output logic [NCH-1:0] set_ready_in_n,
    output logic [NCH-1:0] carrier_sense_in_n,
    output logic [NCH-1:0] ring_sense_in_n,
    output logic third_channel_clock_in
);
    logic [1:0] div_r = 2'h0; // Core cycles per half period of the clock.
    logic clk_r = 1'b0; // Clock level handed to the third channel.
    // The line loops transmit back to receive, or holds a break.
    assign serial_rx_in = line_break ? 4'h0 : serial_tx_out;
    // Asserted handshakes pull low; unused ones idle high.
    assign set_ready_in_n = ~dsr_on;
    assign carrier_sense_in_n = 4'hf;
    assign ring_sense_in_n = 4'hf;
    assign third_channel_clock_in = clk_r;
    // A 16x clock of eight core cycles, standing still when not enabled.
    always @(posedge core_clk) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3) begin
            clk_r <= ~clk_r & clk_on;
        end
    end
endmodule : qupc_line_model

// [quad_uart_pin_control_tb.sv]
// Self-checking bench for the quad pin control core.
`timescale 1ns/1ps
module quad_uart_pin_control_tb;
    import qupc_pkg::*;
    logic core_clk = 1'b0; // Core clock, 100 MHz.
    logic rst = 1'b1; // Power-up reset.
    logic [ADDR_W-1:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic bus_style_in = 1'b1; // Strobe style first.
    logic reset_pin_in = 1'b0; // Inactive in strobe style.
    logic prescaler_strap = 1'b0; // Divide-by-4 at power-up.
    logic osc_in = 1'b0;
    logic clk_on = 1'b0; // Enables the third channel clock.
    logic line_break = 1'b0; // Holds the receive lines low.
    logic [NCH-1:0] dsr_on = 4'h0; // Handshakes asserted by the line.
    logic [NCH-1:0] tx_data_in = 4'h5;
    logic [NCH-1:0] tx_busy_in = 4'h0;
    logic [7:0] reg_rdata;
    logic osc_out, third_channel_clock_in, strobe_bus_style, device_reset;
    logic [NCH-1:0] serial_tx_out, serial_rx_in, rx_data_out, rx_sample_tick;
    logic [NCH-1:0] baud16x_clock_out, terminal_ready_out_n;
    logic [NCH-1:0] spare_out1_or_dir_n, spare_out2_n, set_ready_in_n;
    logic [NCH-1:0] carrier_sense_in_n, ring_sense_in_n;
    int mismatches = 0; // Failed comparisons.
    int check_count = 0; // All comparisons.

    // Clock of 10 ns period.
    always #5 core_clk = ~core_clk;

    qupc_pin_ctrl u_dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .bus_style_in, .reset_pin_in, .prescaler_strap,
        .osc_in, .osc_out, .third_channel_clock_in, .tx_data_in, .tx_busy_in,
        .serial_tx_out, .serial_rx_in, .rx_data_out, .rx_sample_tick,
        .baud16x_clock_out, .terminal_ready_out_n, .spare_out1_or_dir_n,
        .spare_out2_n, .set_ready_in_n, .carrier_sense_in_n,
        .ring_sense_in_n, .strobe_bus_style, .device_reset);

    qupc_line_model u_line (.core_clk, .clk_on, .line_break, .dsr_on,
        .serial_tx_out, .serial_rx_in, .set_ready_in_n, .carrier_sense_in_n,
        .ring_sense_in_n, .third_channel_clock_in);

    // Compares one value and reports a difference at once.
    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Lets n edges pass, then steps past the edge so outputs settle.
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    // One-cycle register write.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle read; the data stand only in the following cycle.
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata);
    endtask : rd

    // Counts sample ticks and 16x clock rises over 40 cycles.
    task automatic ticks(input int ch, input int exp);
        int n;
        int m;
        logic p;
        n = 0;
        m = 0;
        p = baud16x_clock_out[ch];
        repeat (40) begin
            @(posedge core_clk);
            #1;
            n += int'(rx_sample_tick[ch] === 1'b1);
            m += int'(baud16x_clock_out[ch] === 1'b1 && p === 1'b0);
            p = baud16x_clock_out[ch];
        end
        chk("sample ticks", 8'(exp), 8'(n));
        chk("16x clock rises", 8'(exp), 8'(m));
    endtask : ticks

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // Cuts a hang short.
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    // Main sequence.
    initial begin
        cyc(19);
        chk("tx in reset", 8'h0f, 8'(serial_tx_out));
        chk("rx in reset", 8'h0f, 8'(rx_data_out));
        chk("ready in reset", 8'h0f, 8'(terminal_ready_out_n));
        chk("spare2 in reset", 8'h0f, 8'(spare_out2_n));
        @(posedge core_clk);
        rst <= 1'b0;
        osc_in <= 1'b1;
        cyc(5);
        chk("osc copy", 8'h01, 8'(osc_out));
        chk("tx data", 8'h05, 8'(serial_tx_out));
        chk("rx data", 8'h05, 8'(rx_data_out));
        chk("style out", 8'h01, 8'(strobe_bus_style));
        for (int ch = 0; ch < NCH; ch++) begin
            rd(5'(16 + ch), 8'h28);
        end
        dsr_on <= 4'h2;
        cyc(4);
        rd(5'h11, 8'h29);
        rd(5'h14, 8'h00);
        prescaler_strap <= 1'b1;
        cyc(6);
        rd(5'h10, 8'h28);
        wr(5'h00, 8'h0d);
        wr(5'h02, 8'h04);
        wr(5'h03, 8'h00);
        rd(5'h10, 8'h20);
        chk("ready out", 8'h0e, 8'(terminal_ready_out_n));
        chk("spare1 out", 8'h0e, 8'(spare_out1_or_dir_n));
        chk("spare2 out", 8'h0e, 8'(spare_out2_n));
        ticks(0, 10);
        wr(5'h06, 8'h02);
        ticks(1, 5);
        clk_on <= 1'b1;
        cyc(20);
        ticks(2, 5);
        wr(5'h01, 8'h08);
        tx_busy_in <= 4'h1;
        cyc(3);
        chk("direction busy", 8'h0e, 8'(spare_out1_or_dir_n));
        tx_busy_in <= 4'h0;
        cyc(3);
        chk("direction idle", 8'h0f, 8'(spare_out1_or_dir_n));
        @(posedge core_clk);
        line_break <= 1'b1;
        reset_pin_in <= 1'b1;
        cyc(2);
        reset_pin_in <= 1'b0;
        cyc(8);
        chk("short pulse", 8'h00, 8'(device_reset));
        reset_pin_in <= 1'b1;
        cyc(9);
        chk("device reset", 8'h01, 8'(device_reset));
        chk("tx held", 8'h0f, 8'(serial_tx_out));
        chk("rx ignored", 8'h0f, 8'(rx_data_out));
        reset_pin_in <= 1'b0;
        line_break <= 1'b0;
        cyc(6);
        chk("ready cleared", 8'h0f, 8'(terminal_ready_out_n));
        rd(5'h10, 8'h30);
        wr(5'h00, 8'h80);
        rd(5'h10, 8'h38);
        @(posedge core_clk);
        bus_style_in <= 1'b0;
        reset_pin_in <= 1'b1;
        cyc(6);
        rd(5'h10, 8'h18);
        chk("style out", 8'h00, 8'(strobe_bus_style));
        reset_pin_in <= 1'b0;
        cyc(9);
        chk("low reset", 8'h01, 8'(device_reset));
        reset_pin_in <= 1'b1;
        cyc(4);
        chk("low release", 8'h00, 8'(device_reset));
        stop_test();
    end
endmodule : quad_uart_pin_control_tb
